// ===== verilog/sbl_defs.svh
`ifndef SBL_DEFS_SVH
`define SBL_DEFS_SVH
// ----------------------------------------
// clock and serial timing
// ----------------------------------------
`define SBL_CLK_HZ 250000000
`define SBL_BAUD 115200
`define SBL_FRAME_BITS 10
// bit time rounds down, break time rounds up
`define SBL_BIT_CYC (`SBL_CLK_HZ / `SBL_BAUD)
`define SBL_BREAK_CYC ((64'(`SBL_CLK_HZ) * `SBL_FRAME_BITS + `SBL_BAUD - 1) / `SBL_BAUD)
`define SBL_START_TMO_S 60
`define SBL_TMO_CYC (64'(`SBL_CLK_HZ) * `SBL_START_TMO_S)
`define SBL_C_PERIOD_MS 1000
`define SBL_C_CYC (64'(`SBL_CLK_HZ) / 1000 * `SBL_C_PERIOD_MS)
// ----------------------------------------
// characters
// ----------------------------------------
`define SBL_CH_CR 8'h0D
`define SBL_CH_SOH 8'h01
`define SBL_CH_EOT 8'h04
`define SBL_CH_ACK 8'h06
`define SBL_CH_C 8'h43
`define SBL_CH_ONE 8'h31
`define SBL_CH_TWO 8'h32
`define SBL_XM_LAST 7'h7F
`endif

// ===== verilog/sbl_pkg.sv
package sbl_pkg;
  typedef enum {ST_INIT, ST_APP, ST_BRK, ST_CR, ST_MSG, ST_MENU, ST_XSTART, ST_XRX, ST_XEOT} sbl_state_t;
  typedef enum {MSG_MENU, MSG_DONE, MSG_ABORT} sbl_msg_t;
  typedef enum {XM_HDR, XM_NUM, XM_INV, XM_DATA, XM_CRC_HI, XM_CRC_LO} sbl_xm_t;
  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
  } sbl_byte_t;
endpackage

// ===== verilog/sbl_fifo.sv
module sbl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb
  begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push)
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
    if (pop)
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  // data storage needs no reset, guarded by the count
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule

// ===== verilog/sbl_top.sv
`include "sbl_defs.svh"
module sbl_top #(
  parameter int unsigned BIT_CYC = `SBL_BIT_CYC,
  parameter int unsigned BREAK_CYC = 32'(`SBL_BREAK_CYC),
  parameter longint unsigned TMO_CYC = `SBL_TMO_CYC,
  parameter int unsigned C_CYC = 32'(`SBL_C_CYC),
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  input wire logic sleep_request_input,
  input wire logic rts,
  output logic dout,
  input wire logic spi_mode,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic app_valid,
  input wire logic app_call,
  output logic app_run,
  output logic boot_active,
  output logic update_ok,
  output sbl_pkg::sbl_byte_t flash_wr,
  input wire logic flash_ready,
  input wire logic flash_err
);
  localparam MENU_S = "\r\n1 upload\r\n2 run\r\nBL> ";
  localparam DONE_S = "\r\nupload complete\r\n";
  localparam ABORT_S = "\r\nupload aborted\r\n";
  localparam int MENU_L = $bits(MENU_S) / 8;
  localparam int DONE_L = $bits(DONE_S) / 8;
  localparam int ABORT_L = $bits(ABORT_S) / 8;

  // ----------------------------------------
  // uart receiver
  // ----------------------------------------
  logic rx_prev_reg, rx_prev_next, rx_busy_reg, rx_busy_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  sbl_pkg::sbl_byte_t urx_reg, urx_next;
  always_comb
  begin
    rx_prev_next = din;
    rx_busy_next = rx_busy_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    urx_next = '0;
    if (!rx_busy_reg)
    begin
      if (rx_prev_reg && !din)
      begin
        rx_busy_next = 1'b1;
        rx_cnt_next = 16'(BIT_CYC / 2);
        rx_bit_next = 4'h0;
      end
    end
    else if (rx_cnt_reg != 16'h0000)
      rx_cnt_next = rx_cnt_reg - 16'h0001;
    else
    begin
      rx_cnt_next = 16'(BIT_CYC - 1);
      rx_bit_next = rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0 && din)
        rx_busy_next = 1'b0;
      else if (rx_bit_reg == 4'h9)
      begin
        // a low stop bit (break) is dropped
        rx_busy_next = 1'b0;
        urx_next.valid = din;
        urx_next.data = rx_sh_reg;
      end
      else if (rx_bit_reg != 4'h0)
        rx_sh_next = {din, rx_sh_reg[7:1]};
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_prev_reg <= 1'b0;
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      urx_reg <= '0;
    end
    else
    begin
      rx_prev_reg <= rx_prev_next;
      rx_busy_reg <= rx_busy_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      urx_reg <= urx_next;
    end
  end

  // ----------------------------------------
  // uart transmitter and spi slave
  // ----------------------------------------
  sbl_pkg::sbl_byte_t tx_req_reg, tx_req_next, hold_reg, hold_next, srx_reg, srx_next;
  logic tx_busy_reg, tx_busy_next, dout_reg, dout_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [9:0] tx_sh_reg, tx_sh_next;
  logic sck_prev_reg, sck_prev_next, miso_reg, miso_next;
  logic [2:0] sp_cnt_reg, sp_cnt_next;
  logic [7:0] sp_rx_reg, sp_rx_next, sp_tx_reg, sp_tx_next;
  always_comb
  begin
    tx_busy_next = tx_busy_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    hold_next = hold_reg;
    srx_next = '0;
    sck_prev_next = spi_sck;
    sp_cnt_next = sp_cnt_reg;
    sp_rx_next = sp_rx_reg;
    sp_tx_next = sp_tx_reg;
    if (!tx_busy_reg)
    begin
      if (tx_req_reg.valid && !spi_mode)
      begin
        tx_busy_next = 1'b1;
        tx_sh_next = {1'b1, tx_req_reg.data, 1'b0};
        tx_cnt_next = 16'(BIT_CYC - 1);
        tx_bit_next = 4'h0;
      end
    end
    else if (tx_cnt_reg != 16'h0000)
      tx_cnt_next = tx_cnt_reg - 16'h0001;
    else
    begin
      tx_cnt_next = 16'(BIT_CYC - 1);
      tx_sh_next = {1'b1, tx_sh_reg[9:1]};
      tx_bit_next = tx_bit_reg + 4'h1;
      if (tx_bit_reg == 4'h9)
        tx_busy_next = 1'b0;
    end
    dout_next = tx_busy_reg ? tx_sh_reg[0] : 1'b1;
    // sck from the master, sampled as data
    // reply waits in hold for a byte slot, so none is lost while deselected
    if (spi_cs_n)
      sp_cnt_next = 3'h0;
    else if (spi_sck && !sck_prev_reg)
    begin
      sp_rx_next = {sp_rx_reg[6:0], spi_mosi};
      sp_cnt_next = sp_cnt_reg + 3'h1;
      if (sp_cnt_reg == 3'h7)
      begin
        srx_next.valid = 1'b1;
        srx_next.data = {sp_rx_reg[6:0], spi_mosi};
        sp_tx_next = hold_reg.valid ? hold_reg.data : 8'hFF;
        hold_next.valid = 1'b0;
      end
    end
    // no shift after the 8th bit: next byte was just loaded
    else if (!spi_sck && sck_prev_reg && sp_cnt_reg != 3'h0)
      sp_tx_next = {sp_tx_reg[6:0], 1'b1};
    if (tx_req_reg.valid && spi_mode)
      hold_next = tx_req_reg;
    miso_next = sp_tx_reg[7];
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF;
      dout_reg <= 1'b1;
      hold_reg <= '0;
      srx_reg <= '0;
      sck_prev_reg <= 1'b0;
      sp_cnt_reg <= 3'h0;
      sp_rx_reg <= 8'h00;
      sp_tx_reg <= 8'hFF;
      miso_reg <= 1'b1;
    end
    else
    begin
      tx_busy_reg <= tx_busy_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      dout_reg <= dout_next;
      hold_reg <= hold_next;
      srx_reg <= srx_next;
      sck_prev_reg <= sck_prev_next;
      sp_cnt_reg <= sp_cnt_next;
      sp_rx_reg <= sp_rx_next;
      sp_tx_reg <= sp_tx_next;
      miso_reg <= miso_next;
    end
  end

  // ----------------------------------------
  // image buffer towards flash
  // ----------------------------------------
  sbl_pkg::sbl_byte_t push_reg, push_next, fl_reg, fl_next;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  sbl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_reg.valid),
    .in_ready(fifo_in_ready),
    .in_data(push_reg.data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  assign fifo_out_ready = !fl_reg.valid || flash_ready;
  always_comb
  begin
    fl_next = fl_reg;
    if (fifo_out_ready)
      fl_next = '{valid: fifo_out_valid, data: fifo_out_data};
  end

  // ----------------------------------------
  // entry, menu and image load control
  // ----------------------------------------
  sbl_pkg::sbl_state_t st_reg, st_next;
  sbl_pkg::sbl_msg_t msg_reg, msg_next;
  sbl_pkg::sbl_xm_t xm_reg, xm_next;
  sbl_pkg::sbl_byte_t rxb;
  logic [5:0] idx_reg, idx_next;
  logic [7:0] blk_reg, blk_next, crc_hi_reg, crc_hi_next, ch;
  logic [6:0] dcnt_reg, dcnt_next;
  logic [15:0] crc_reg, crc_next;
  logic [35:0] tmo_reg, tmo_next;
  logic [31:0] ctmo_reg, ctmo_next, brk_reg, brk_next;
  logic ok_reg, ok_next, run_reg, run_next, boot_reg, boot_next;
  logic tx_free, last, fail, loading;
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
    return r;
  endfunction
  assign rxb = spi_mode ? srx_reg : urx_reg;
  assign tx_free = !tx_req_reg.valid && !(spi_mode ? hold_reg.valid : tx_busy_reg);
  assign loading = st_reg == sbl_pkg::ST_XSTART || st_reg == sbl_pkg::ST_XRX || st_reg == sbl_pkg::ST_XEOT;
  always_comb
  begin
    st_next = st_reg;
    msg_next = msg_reg;
    xm_next = xm_reg;
    idx_next = idx_reg;
    blk_next = blk_reg;
    crc_hi_next = crc_hi_reg;
    dcnt_next = dcnt_reg;
    crc_next = crc_reg;
    tmo_next = tmo_reg;
    ctmo_next = ctmo_reg;
    ok_next = ok_reg;
    run_next = run_reg;
    boot_next = boot_reg;
    tx_req_next = '0;
    push_next = '0;
    brk_next = din ? 32'h0000_0000 : (brk_reg < BREAK_CYC ? brk_reg + 32'h1 : brk_reg);
    fail = loading && (flash_err || (push_reg.valid && !fifo_in_ready));
    unique case (msg_reg)
      sbl_pkg::MSG_MENU:
      begin
        ch = MENU_S[8 * (MENU_L - 1 - int'(idx_reg)) +: 8];
        last = int'(idx_reg) == MENU_L - 1;
      end
      sbl_pkg::MSG_DONE:
      begin
        ch = DONE_S[8 * (DONE_L - 1 - int'(idx_reg)) +: 8];
        last = int'(idx_reg) == DONE_L - 1;
      end
      sbl_pkg::MSG_ABORT:
      begin
        ch = ABORT_S[8 * (ABORT_L - 1 - int'(idx_reg)) +: 8];
        last = int'(idx_reg) == ABORT_L - 1;
      end
    endcase
    unique case (st_reg)
      sbl_pkg::ST_INIT:
      begin
        if (!app_valid)
          st_next = sbl_pkg::ST_MSG;
        else if (!sleep_request_input && rts && !din)
          st_next = sbl_pkg::ST_BRK;
        else
          st_next = sbl_pkg::ST_APP;
        run_next = st_next == sbl_pkg::ST_APP;
        boot_next = !run_next;
      end
      sbl_pkg::ST_APP:
      begin
        if (app_call)
        begin
          st_next = sbl_pkg::ST_MSG;
          run_next = 1'b0;
          boot_next = 1'b1;
        end
      end
      sbl_pkg::ST_BRK:
      begin
        if (din)
        begin
          st_next = brk_reg >= BREAK_CYC ? sbl_pkg::ST_CR : sbl_pkg::ST_APP;
          run_next = st_next == sbl_pkg::ST_APP;
          boot_next = !run_next;
        end
      end
      sbl_pkg::ST_CR:
      begin
        if (rxb.valid && rxb.data == `SBL_CH_CR)
          st_next = sbl_pkg::ST_MSG;
      end
      sbl_pkg::ST_MSG:
      begin
        if (tx_free)
        begin
          tx_req_next = '{valid: 1'b1, data: ch};
          idx_next = idx_reg + 6'h01;
          if (last)
          begin
            idx_next = 6'h00;
            msg_next = sbl_pkg::MSG_MENU;
            if (msg_reg == sbl_pkg::MSG_MENU)
              st_next = sbl_pkg::ST_MENU;
          end
        end
      end
      sbl_pkg::ST_MENU:
      begin
        if (rxb.valid && rxb.data == `SBL_CH_ONE)
        begin
          st_next = sbl_pkg::ST_XSTART;
          tmo_next = '0;
          ctmo_next = C_CYC;
          blk_next = 8'h01;
          ok_next = 1'b0;
        end
        else if (rxb.valid && rxb.data == `SBL_CH_TWO && (ok_reg || app_valid))
        begin
          st_next = sbl_pkg::ST_APP;
          run_next = 1'b1;
          boot_next = 1'b0;
        end
      end
      sbl_pkg::ST_XSTART:
      begin
        tmo_next = tmo_reg + 36'h1;
        ctmo_next = ctmo_reg + 32'h1;
        // 'C' repeats until the sender starts
        if (ctmo_reg >= C_CYC && tx_free)
        begin
          tx_req_next = '{valid: 1'b1, data: `SBL_CH_C};
          ctmo_next = '0;
        end
        if (tmo_reg >= 36'(TMO_CYC))
          fail = 1'b1;
        if (rxb.valid && rxb.data == `SBL_CH_SOH)
        begin
          st_next = sbl_pkg::ST_XRX;
          xm_next = sbl_pkg::XM_NUM;
        end
      end
      sbl_pkg::ST_XRX:
      begin
        if (rxb.valid)
        begin
          unique case (xm_reg)
            sbl_pkg::XM_HDR:
            begin
              xm_next = sbl_pkg::XM_NUM;
              if (rxb.data == `SBL_CH_EOT)
                st_next = sbl_pkg::ST_XEOT;
              else if (rxb.data != `SBL_CH_SOH)
                fail = 1'b1;
            end
            sbl_pkg::XM_NUM:
            begin
              xm_next = sbl_pkg::XM_INV;
              fail = fail || rxb.data != blk_reg;
            end
            sbl_pkg::XM_INV:
            begin
              xm_next = sbl_pkg::XM_DATA;
              fail = fail || rxb.data != ~blk_reg;
              dcnt_next = 7'h00;
              crc_next = 16'h0000;
            end
            sbl_pkg::XM_DATA:
            begin
              // streamed on: a bad block cannot be retried
              push_next = rxb;
              crc_next = crc_upd(crc_reg, rxb.data);
              dcnt_next = dcnt_reg + 7'h01;
              if (dcnt_reg == `SBL_XM_LAST)
                xm_next = sbl_pkg::XM_CRC_HI;
            end
            sbl_pkg::XM_CRC_HI:
            begin
              crc_hi_next = rxb.data;
              xm_next = sbl_pkg::XM_CRC_LO;
            end
            sbl_pkg::XM_CRC_LO:
            begin
              xm_next = sbl_pkg::XM_HDR;
              fail = fail || {crc_hi_reg, rxb.data} != crc_reg;
              tx_req_next = '{valid: !fail, data: `SBL_CH_ACK};
              blk_next = blk_reg + 8'h01;
            end
          endcase
        end
      end
      sbl_pkg::ST_XEOT:
      begin
        // drain buffer before declaring success
        if (!push_reg.valid && !fifo_out_valid && !fl_reg.valid && tx_free)
        begin
          tx_req_next = '{valid: 1'b1, data: `SBL_CH_ACK};
          ok_next = 1'b1;
          st_next = sbl_pkg::ST_MSG;
          msg_next = sbl_pkg::MSG_DONE;
          idx_next = 6'h00;
        end
      end
    endcase
    if (fail)
    begin
      st_next = sbl_pkg::ST_MSG;
      msg_next = sbl_pkg::MSG_ABORT;
      idx_next = 6'h00;
      ok_next = 1'b0;
      push_next = '0;
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= sbl_pkg::ST_INIT;
      msg_reg <= sbl_pkg::MSG_MENU;
      xm_reg <= sbl_pkg::XM_HDR;
      idx_reg <= 6'h00;
      blk_reg <= 8'h01;
      crc_hi_reg <= 8'h00;
      dcnt_reg <= 7'h00;
      crc_reg <= 16'h0000;
      tmo_reg <= '0;
      ctmo_reg <= '0;
      brk_reg <= '0;
      ok_reg <= 1'b0;
      run_reg <= 1'b0;
      boot_reg <= 1'b0;
      tx_req_reg <= '0;
      push_reg <= '0;
      fl_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      msg_reg <= msg_next;
      xm_reg <= xm_next;
      idx_reg <= idx_next;
      blk_reg <= blk_next;
      crc_hi_reg <= crc_hi_next;
      dcnt_reg <= dcnt_next;
      crc_reg <= crc_next;
      tmo_reg <= tmo_next;
      ctmo_reg <= ctmo_next;
      brk_reg <= brk_next;
      ok_reg <= ok_next;
      run_reg <= run_next;
      boot_reg <= boot_next;
      tx_req_reg <= tx_req_next;
      push_reg <= push_next;
      fl_reg <= fl_next;
    end
  end
  assign dout = dout_reg;
  assign spi_miso = miso_reg;
  assign app_run = run_reg;
  assign boot_active = boot_reg;
  assign update_ok = ok_reg;
  assign flash_wr = fl_reg;
endmodule

// ===== sim/sbl_host.sv
module sbl_host #(
  parameter int unsigned BIT_CYC = 4
) (
  input wire logic clk,
  input wire logic dout,
  output logic din,
  output logic sleep_request_input,
  output logic rts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  logic [7:0] rx_byte;

  initial
  begin
    din = 1'h1;
    sleep_request_input = 1'h1;
    rts = 1'h0;
  end

  task automatic set_straps(input bit entry);
    sleep_request_input = !entry;
    rts = entry;
    din = !entry;
  endtask

  task automatic line_idle();
    din = 1'h1;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      din = frame[i];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
  endtask

  // receiver drops frames with low stop bit
  always
  begin
    @(negedge dout);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk);
      rx_byte = {dout, rx_byte[7:1]};
    end
    repeat (BIT_CYC) @(posedge clk);
    if (dout)
      rx_q.push_back(rx_byte);
  end
endmodule

// ===== sim/sbl_top_monitor.sv
module sbl_top_mon #(
  parameter int unsigned BIT_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic app_valid,
  input wire logic app_call,
  input wire logic app_run,
  input wire logic boot_active,
  input wire logic update_ok,
  input wire logic dout,
  input wire logic flash_ready,
  input wire logic flash_err,
  input wire sbl_pkg::sbl_byte_t flash_wr
);
  logic last_reg;
  logic last_next;
  logic [15:0] run_reg;
  logic [15:0] run_next;

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // --------------------------------
  // cycles dout has held its level
  // --------------------------------
  always_comb
  begin
    last_next = dout;
    run_next = run_reg;
    if (dout != last_reg)
      run_next = 16'h0001;
    else if (run_reg != 16'hFFFF)
      run_next = run_reg + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_reg <= 1'h1;
      run_reg <= 16'hFFFF;
    end
    else
    begin
      last_reg <= last_next;
      run_reg <= run_next;
    end
  end

  // --------------------------------
  // checks
  // --------------------------------
  a_bit_hold: assert property (dout != last_reg |-> run_reg >= 16'(BIT_CYC))
    else $error("dout level shorter than one bit time");
  a_run_excl: assert property (!(app_run && boot_active))
    else $error("application and loader both active");
  a_call_enter: assert property (app_run && app_call |-> ##[1:4] (boot_active && !app_run))
    else $error("application call did not enter loader");
  a_no_return: assert property ($fell(boot_active) |-> ##[0:1] app_run)
    else $error("loader left without starting firmware");
  a_empty_boot: assert property ($past(rst) && !app_valid |-> ##[1:2] boot_active)
    else $error("loader not started without application");
  a_flash_hold: assert property (flash_wr.valid && !flash_ready && !flash_err && !$past(flash_err)
    |=> flash_wr.valid && $stable(flash_wr.data))
    else $error("flash byte dropped before taken");
  a_flash_boot: assert property (flash_wr.valid |-> boot_active && !update_ok)
    else $error("flash write outside a load");
  a_ok_boot: assert property ($rose(update_ok) |-> boot_active && !flash_wr.valid)
    else $error("update flagged with bytes pending");
  a_start_gate: assert property ($rose(app_run) && $past(boot_active) |-> $past(update_ok) || app_valid)
    else $error("firmware started without an image");
endmodule

bind sbl_top sbl_top_mon #(.BIT_CYC(BIT_CYC)) u_sbl_top_mon (.clk(clk), .rst(rst), .app_valid(app_valid),
  .app_call(app_call), .app_run(app_run), .boot_active(boot_active), .update_ok(update_ok), .dout(dout),
  .flash_ready(flash_ready), .flash_err(flash_err), .flash_wr(flash_wr));

// ===== sim/test_serial_bootloader_entry_update.sv
module test_serial_bootloader_entry_update;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BIT_CYC = 4;
  localparam longint unsigned TMO_CYC = 2000;
  localparam int unsigned BRK_CYC = 30;
  localparam int unsigned C_CYC = 200;
  localparam int unsigned DEPTH = 4;
  localparam string MENU = "\r\n1 upload\r\n2 run\r\nBL> ";
  logic clk, rst, app_valid, app_call, flash_ready, flash_err, spi_mode, spi_sck, spi_cs_n, spi_mosi;
  logic app_run, boot_active, update_ok, dout, din, sleep_request_input, rts, spi_miso;
  sbl_pkg::sbl_byte_t flash_wr;
  int fail_count, check_count;
  logic [7:0] flash_q[$];
  logic [7:0] blk[128];
  logic [7:0] rb;

`define SBL_CHECK(got, exp, msg) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("BAD %0t %s", $time, msg); \
    end \
  end

  sbl_top #(.BIT_CYC(BIT_CYC), .BREAK_CYC(BRK_CYC), .TMO_CYC(TMO_CYC), .C_CYC(C_CYC), .FIFO_DEPTH(DEPTH)) u_sbl_top (
    .clk(clk), .rst(rst), .din(din), .sleep_request_input(sleep_request_input), .rts(rts), .dout(dout),
    .spi_mode(spi_mode), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .app_valid(app_valid), .app_call(app_call), .app_run(app_run), .boot_active(boot_active),
    .update_ok(update_ok), .flash_wr(flash_wr), .flash_ready(flash_ready), .flash_err(flash_err));
  sbl_host #(.BIT_CYC(BIT_CYC)) u_sbl_host (.clk(clk), .dout(dout), .din(din),
    .sleep_request_input(sleep_request_input), .rts(rts));

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // flash sink stalls every other cycle
  always @(negedge clk) flash_ready <= !flash_ready;
  always @(posedge clk) if (flash_wr.valid && flash_ready) flash_q.push_back(flash_wr.data);

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_reset(input bit entry, input logic av);
    @(negedge clk);
    rst = 1'h1;
    app_valid = av;
    u_sbl_host.set_straps(entry);
    repeat (16) @(negedge clk);
    rst = 1'h0;
    u_sbl_host.rx_q.delete();
    flash_q.delete();
  endtask

  task automatic get_byte(input bit skip_c);
    rb = 8'hXX;
    for (int n = 0; n < 5000; n++)
    begin
      @(negedge clk);
      if (u_sbl_host.rx_q.size() > 0)
      begin
        rb = u_sbl_host.rx_q.pop_front();
        if (!(skip_c && rb == 8'h43))
          return;
      end
    end
    fail_count++;
    $display("BAD %0t no reply byte", $time);
  endtask

  task automatic expect_str(input string s, input bit skip_c);
    for (int i = 0; i < s.len(); i++)
    begin
      get_byte(skip_c);
      `SBL_CHECK(rb, 8'(s[i]), "reply text")
    end
  endtask

  task automatic wait_high(ref logic s);
    for (int n = 0; n < 200 && s !== 1'h1; n++) @(negedge clk);
  endtask

  function automatic logic [15:0] crc16();
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 128; i++)
    begin
      c ^= {blk[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? {c[14:0], 1'h0} ^ 16'h1021 : {c[14:0], 1'h0};
    end
    return c;
  endfunction

  task automatic send_block(input int upto);
    logic [15:0] c;
    c = crc16();
    u_sbl_host.send_byte(8'h01);
    u_sbl_host.send_byte(8'h01);
    u_sbl_host.send_byte(8'hFE);
    for (int i = 0; i < upto; i++) u_sbl_host.send_byte(blk[i]);
    if (upto == 128)
    begin
      u_sbl_host.send_byte(c[15:8]);
      u_sbl_host.send_byte(c[7:0]);
    end
  endtask

  task automatic start_load(input int upto);
    do_reset(0, 1'h0);
    expect_str(MENU, 0);
    u_sbl_host.send_byte(8'h31);
    get_byte(0);
    `SBL_CHECK(rb, 8'h43, "no crc request")
    send_block(upto);
  endtask

  task automatic t_entry();
    do_reset(1, 1'h1);
    repeat (40) @(negedge clk);
    u_sbl_host.line_idle();
    repeat (8) @(negedge clk);
    u_sbl_host.send_byte(8'h0D);
    expect_str(MENU, 0);
    `SBL_CHECK(boot_active, 1'h1, "loader not entered")
  endtask

  task automatic t_short_break();
    do_reset(1, 1'h1);
    repeat (10) @(negedge clk);
    u_sbl_host.line_idle();
    repeat (100) @(negedge clk);
    `SBL_CHECK(app_run, 1'h1, "short break entered loader")
  endtask

  task automatic t_app_call();
    do_reset(0, 1'h1);
    repeat (4) @(negedge clk);
    `SBL_CHECK(app_run, 1'h1, "application not started")
    app_call = 1'h1;
    @(negedge clk);
    app_call = 1'h0;
    expect_str(MENU, 0);
    `SBL_CHECK(app_run, 1'h0, "application still running")
  endtask

  task automatic t_upload();
    start_load(128);
    get_byte(1);
    `SBL_CHECK(rb, 8'h06, "block not acked")
    u_sbl_host.send_byte(8'h04);
    get_byte(1);
    `SBL_CHECK(rb, 8'h06, "end not acked")
    expect_str({"\r\nupload complete\r\n", MENU}, 0);
    `SBL_CHECK(flash_q.size(), 128, "flash byte count")
    for (int i = 0; i < 128; i++) `SBL_CHECK(flash_q[i], blk[i], "flash byte")
    `SBL_CHECK(update_ok, 1'h1, "update not flagged")
    u_sbl_host.send_byte(8'h32);
    wait_high(app_run);
    `SBL_CHECK(app_run, 1'h1, "firmware not started")
  endtask

  task automatic t_timeout();
    time t0;
    do_reset(0, 1'h0);
    expect_str(MENU, 0);
    u_sbl_host.send_byte(8'h31);
    t0 = $time;
    expect_str("\r", 1);
    `SBL_CHECK(($time - t0) / 4 inside {[TMO_CYC:TMO_CYC + 100]}, 1'h1, "abort time")
    expect_str({"\nupload aborted\r\n", MENU}, 1);
  endtask

  task automatic t_flash_err();
    start_load(8);
    flash_err = 1'h1;
    repeat (4) @(negedge clk);
    flash_err = 1'h0;
    expect_str({"\r\nupload aborted\r\n", MENU}, 1);
    `SBL_CHECK(update_ok, 1'h0, "failed load flagged ok")
  endtask

  task automatic t_reset_mid();
    start_load(64);
    do_reset(0, 1'h0);
    expect_str(MENU, 0);
    `SBL_CHECK(update_ok, 1'h0, "reset load flagged ok")
    u_sbl_host.send_byte(8'h32);
    repeat (20) @(negedge clk);
    `SBL_CHECK(app_run, 1'h0, "start without image")
  endtask

  // mode 0, msb first, reply sampled at sck rise
  task automatic spi_xfer(input logic [7:0] mo, input logic [7:0] exp);
    logic [7:0] mi;
    @(negedge clk);
    spi_cs_n = 1'h0;
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi = mo[i];
      repeat (4) @(negedge clk);
      spi_sck = 1'h1;
      mi[i] = spi_miso;
      repeat (4) @(negedge clk);
      spi_sck = 1'h0;
    end
    repeat (4) @(negedge clk);
    spi_cs_n = 1'h1;
    `SBL_CHECK(mi, exp, "spi reply")
  endtask

  task automatic t_spi();
    spi_mode = 1'h1;
    do_reset(0, 1'h0);
    spi_xfer(8'h00, 8'hFF);
    spi_xfer(8'h00, 8'(MENU[0]));
    spi_xfer(8'h00, 8'(MENU[1]));
    `SBL_CHECK(dout, 1'h1, "uart used in spi mode")
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    rst = 1'h1;
    app_valid = 1'h1;
    app_call = 1'h0;
    flash_ready = 1'h0;
    flash_err = 1'h0;
    spi_mode = 1'h0;
    spi_sck = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
    fail_count = 0;
    check_count = 0;
    for (int i = 0; i < 128; i++) blk[i] = 8'(i) ^ 8'h5A;
    t_entry();
    t_short_break();
    t_app_call();
    t_upload();
    t_timeout();
    t_flash_err();
    t_reset_mid();
    t_spi();
    give_verdict();
  end
endmodule
